// file: clock_mask_regs.svh
`ifndef CLOCK_MASK_REGS_SVH
`define CLOCK_MASK_REGS_SVH

// Register byte offsets
`define OFS_CLOCK_MASK     8'h00
`define OFS_BRIDGE_CTRL    8'h04
`define OFS_GPIO           8'h08
`define OFS_STATUS         8'h0c

// Bridge control fields
`define CTRL_SEC_RESET     0
`define CTRL_LIVE_MODE     1
`define CTRL_IO_EN         2
`define CTRL_MEM_EN        3
`define CTRL_MASTER_EN     4
`define CTRL_LAMP          5
`define CTRL_RESET_VAL     6'h20

// GPIO register fields (low bit of each 4-bit field)
`define GPIO_OUT_SET       0
`define GPIO_OUT_CLR       4
`define GPIO_OE_SET        8
`define GPIO_OE_CLR        12
`define GPIO_IN            16

// Status fields
`define STAT_IO_EFF        0
`define STAT_MEM_EFF       1
`define STAT_MASTER_EFF    2
`define STAT_LIVE_ACTIVE   3
`define STAT_HOTSWAP       4
`define STAT_SHIFT_DONE    5
`define STAT_SEC_RESET_N   6
`define STAT_EJECTOR_N     7
`define STAT_INSERT_EVT    8

// Mask shift and reset timing
`define MASK_BITS          16
`define MASK_RESET_VAL     16'h0000
`define CLK_PERIOD_NS      20
`define SEC_RESET_HOLD_US  100
`define SEC_RESET_HOLD_CYC ((`SEC_RESET_HOLD_US * 1000) / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// file: clock_mask_pkg.sv
package clock_mask_pkg;

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_SHIFT,
    ST_HOLD,
    ST_RUN,
    ST_SW_RESET
  } seq_e;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_s;

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } gpio_drive_s;

  typedef struct packed {
    logic io;
    logic mem;
    logic master;
  } enables_s;

  typedef struct packed {
    seq_e        seq;
    logic [15:0] cnt;
    logic [15:0] mask;
    logic [5:0]  ctrl;
    gpio_drive_s gpio_reg;
    gpio_drive_s gpio_pin;
    logic        sec_reset_n;
    logic        div;
    logic        running;
    enables_s    eff;
    logic        live_active;
    logic        ret_cpl;
    logic        insert_evt;
    logic        ejector_q;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_s;

endpackage

// file: clock_mask_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_mask_regs.svh"

module clock_mask_ctrl (
  input  wire logic                      aclk,                 // Primary clock
  input  wire logic                      aresetn,              // Primary reset
  input  wire clock_mask_pkg::axil_req_s axil_req,             // Register bus in
  output      clock_mask_pkg::axil_rsp_s axil_rsp,             // Register bus out
  input  wire logic                      mask_serial_in,       // Serial mask data
  input  wire logic [3:0]                gpio_in,              // Pin levels
  output logic      [3:0]                gpio_out,             // Pin drive values
  output logic      [3:0]                gpio_oe,              // Pin drive enables
  input  wire logic                      primary_speed_select,   // Primary fast
  input  wire logic                      secondary_speed_select, // Secondary fast
  input  wire logic                      mode_select_0,        // Mode strap 0
  input  wire logic                      mode_select_1,        // Mode strap 1
  output logic      [9:0]                secondary_clock_output, // Clock outs
  output logic                           secondary_reset_n,    // Secondary reset
  output clock_mask_pkg::enables_s       target_enables,       // Effective enables
  output logic                           return_completions,   // Delayed cpl ok
  output logic                           insertion_event_n,    // Hot-swap event
  output logic                           removal_ready_lamp    // Hot-swap lamp
);

  parameter logic [15:0] HOLD_CYCLES = 16'(`SEC_RESET_HOLD_CYC);

  clock_mask_pkg::state_s cur_ff;
  clock_mask_pkg::state_s nxt_cur;

  // Set when any mask bit owning this output is set
  function automatic logic clk_disabled(input logic [15:0] m,
                                        input int unsigned idx);
    logic d;
    d = 1'b0;
    if (idx < 4) begin
      d = m[2*idx] | m[2*idx+1];
    end else if (idx < 10) begin
      d = m[idx+4];
    end
    return d;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      r[8*b +: 8] = {8{s[b]}};
    end
    return r;
  endfunction

  logic hotswap;
  logic live_mode;
  logic live_mask;
  logic slow;
  logic do_write;
  logic [31:0] wd;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [15:0] status_word;

  always_comb begin
    hotswap   = ~mode_select_0 & ~mode_select_1;
    live_mode = cur_ff.ctrl[`CTRL_LIVE_MODE] & ~cur_ff.gpio_reg.oe[3]
                & ~hotswap;
    live_mask = live_mode & gpio_in[3];
    slow      = primary_speed_select & ~secondary_speed_select;
    do_write  = cur_ff.aw_held & cur_ff.w_held & ~cur_ff.bvalid;
    wmask     = strb_mask(cur_ff.w_strb);
    wd        = cur_ff.w_data & wmask;
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[`STAT_IO_EFF]      = cur_ff.eff.io;
    status_word[`STAT_MEM_EFF]     = cur_ff.eff.mem;
    status_word[`STAT_MASTER_EFF]  = cur_ff.eff.master;
    status_word[`STAT_LIVE_ACTIVE] = cur_ff.live_active;
    status_word[`STAT_HOTSWAP]     = hotswap;
    status_word[`STAT_SHIFT_DONE]  = (cur_ff.seq != clock_mask_pkg::ST_LOAD)
                                     && (cur_ff.seq != clock_mask_pkg::ST_SHIFT);
    status_word[`STAT_SEC_RESET_N] = cur_ff.sec_reset_n;
    status_word[`STAT_EJECTOR_N]   = cur_ff.ejector_q;
    status_word[`STAT_INSERT_EVT]  = cur_ff.insert_evt;
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (axil_req.araddr[7:0])
      `OFS_CLOCK_MASK:  rd_val[15:0] = cur_ff.mask;
      `OFS_BRIDGE_CTRL: rd_val[5:0]  = cur_ff.ctrl;
      `OFS_GPIO: begin
        rd_val[`GPIO_OUT_SET +: 4] = cur_ff.gpio_reg.out;
        rd_val[`GPIO_OE_SET +: 4]  = cur_ff.gpio_reg.oe;
        rd_val[`GPIO_IN +: 4]      = gpio_in;
      end
      `OFS_STATUS:      rd_val[15:0] = status_word;
      default:          rd_hit = 1'b0;
    endcase
    if (axil_req.araddr[31:8] != 24'h00_0000) begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    nxt_cur = cur_ff;

    // Write address and data are taken independently
    if (axil_req.awvalid && !cur_ff.aw_held && !cur_ff.bvalid) begin
      nxt_cur.aw_held = 1'b1;
      nxt_cur.aw_addr = (axil_req.awaddr[31:8] == 24'h00_0000)
                        ? axil_req.awaddr[7:0] : 8'hff;
    end
    if (axil_req.wvalid && !cur_ff.w_held && !cur_ff.bvalid) begin
      nxt_cur.w_held = 1'b1;
      nxt_cur.w_data = axil_req.wdata;
      nxt_cur.w_strb = axil_req.wstrb;
    end
    if (cur_ff.bvalid && axil_req.bready) begin
      nxt_cur.bvalid = 1'b0;
    end
    if (axil_req.arvalid && !cur_ff.rvalid) begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rdata  = rd_hit ? rd_val : 32'h0000_0000;
      nxt_cur.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (cur_ff.rvalid && axil_req.rready) begin
      nxt_cur.rvalid = 1'b0;
    end

    // Config writes stay live whatever the masking state
    if (do_write) begin
      nxt_cur.aw_held = 1'b0;
      nxt_cur.w_held  = 1'b0;
      nxt_cur.bvalid  = 1'b1;
      nxt_cur.bresp   = `RESP_OKAY;
      unique case (cur_ff.aw_addr)
        `OFS_CLOCK_MASK: begin
          // Until the shift is over the serial stream owns the mask
          if (cur_ff.seq != clock_mask_pkg::ST_LOAD
              && cur_ff.seq != clock_mask_pkg::ST_SHIFT) begin
            nxt_cur.mask = (cur_ff.mask & ~wmask[15:0])
                           | wd[15:0];
          end
        end
        `OFS_BRIDGE_CTRL: begin
          nxt_cur.ctrl = (cur_ff.ctrl & ~wmask[5:0])
                         | wd[5:0];
        end
        `OFS_GPIO: begin
          nxt_cur.gpio_reg.out = (cur_ff.gpio_reg.out
                                  | wd[`GPIO_OUT_SET +: 4])
                                 & ~wd[`GPIO_OUT_CLR +: 4];
          nxt_cur.gpio_reg.oe  = (cur_ff.gpio_reg.oe
                                  | wd[`GPIO_OE_SET +: 4])
                                 & ~wd[`GPIO_OE_CLR +: 4];
        end
        `OFS_STATUS: begin
          if (wd[`STAT_INSERT_EVT]) begin
            nxt_cur.insert_evt = 1'b0;
          end
        end
        default: nxt_cur.bresp = `RESP_SLVERR;
      endcase
    end

    // Mask load and shift sequence
    nxt_cur.gpio_pin.out = 4'h0;
    nxt_cur.gpio_pin.oe  = 4'h0;
    unique case (cur_ff.seq)
      clock_mask_pkg::ST_LOAD: begin
        nxt_cur.gpio_pin.oe  = 4'b0101;
        nxt_cur.gpio_pin.out = 4'b0001;
        nxt_cur.seq = clock_mask_pkg::ST_SHIFT;
        nxt_cur.cnt = 16'h0000;
      end
      clock_mask_pkg::ST_SHIFT: begin
        nxt_cur.gpio_pin.oe  = 4'b0101;
        nxt_cur.gpio_pin.out = 4'b0100;
        // Pins are registered: a bit stands only after a shift cycle
        if (cur_ff.gpio_pin.out[2]) begin
          nxt_cur.mask = {mask_serial_in, cur_ff.mask[15:1]};
          nxt_cur.cnt  = cur_ff.cnt + 16'h0001;
          if (cur_ff.cnt == 16'(`MASK_BITS - 1)) begin
            // Pins drop here; the input is never sampled again
            nxt_cur.seq = clock_mask_pkg::ST_HOLD;
            nxt_cur.cnt = 16'h0000;
            nxt_cur.gpio_pin.oe  = 4'h0;
            nxt_cur.gpio_pin.out = 4'h0;
          end
        end
      end
      clock_mask_pkg::ST_HOLD: begin
        nxt_cur.cnt = cur_ff.cnt + 16'h0001;
        if (cur_ff.ctrl[`CTRL_SEC_RESET]) begin
          nxt_cur.seq = clock_mask_pkg::ST_SW_RESET;
        end else if (cur_ff.cnt >= HOLD_CYCLES - 16'h0001) begin
          nxt_cur.seq = clock_mask_pkg::ST_RUN;
          nxt_cur.sec_reset_n = 1'b1;
        end
      end
      clock_mask_pkg::ST_RUN: begin
        nxt_cur.gpio_pin = cur_ff.gpio_reg;
        if (cur_ff.ctrl[`CTRL_SEC_RESET]) begin
          nxt_cur.seq = clock_mask_pkg::ST_SW_RESET;
          nxt_cur.sec_reset_n = 1'b0;
        end
      end
      clock_mask_pkg::ST_SW_RESET: begin
        nxt_cur.gpio_pin = cur_ff.gpio_reg;
        nxt_cur.sec_reset_n = 1'b0;
        if (!cur_ff.ctrl[`CTRL_SEC_RESET]) begin
          nxt_cur.seq = clock_mask_pkg::ST_HOLD;
          nxt_cur.cnt = 16'h0000;
        end
      end
      default: nxt_cur.seq = clock_mask_pkg::ST_LOAD;
    endcase

    // Live insertion: written bits kept, effective bits masked
    nxt_cur.live_active = live_mask;
    nxt_cur.eff.io      = cur_ff.ctrl[`CTRL_IO_EN] & ~live_mask;
    nxt_cur.eff.mem     = cur_ff.ctrl[`CTRL_MEM_EN] & ~live_mask;
    nxt_cur.eff.master  = cur_ff.ctrl[`CTRL_MASTER_EN] & ~live_mask;
    nxt_cur.ret_cpl     = ~live_mask;

    // Ejector change flags an event; a new change beats a clear
    nxt_cur.ejector_q = hotswap ? gpio_in[3] : 1'b1;
    if (hotswap && (gpio_in[3] != cur_ff.ejector_q)) begin
      nxt_cur.insert_evt = 1'b1;
    end

    nxt_cur.running = 1'b1;
    nxt_cur.div     = cur_ff.running ? ~cur_ff.div : 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_ff             <= '0;
      cur_ff.seq         <= clock_mask_pkg::ST_LOAD;
      cur_ff.mask        <= `MASK_RESET_VAL;
      cur_ff.ctrl        <= `CTRL_RESET_VAL;
      cur_ff.ret_cpl     <= 1'b1;
      cur_ff.ejector_q   <= 1'b1;
      cur_ff.sec_reset_n <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Clocks are gated straight from the primary clock so full speed keeps
  // its phase; slow mode runs instead from the registered divide-by-two div
  logic clk_src;
  assign clk_src = slow ? cur_ff.div : aclk;

  generate
    for (genvar i = 0; i < 10; i++) begin : g_clk
      assign secondary_clock_output[i] =
        !cur_ff.running ? 1'b0 :
        clk_disabled(cur_ff.mask, i) ? 1'b1 : clk_src;
    end
  endgenerate

  assign gpio_out           = cur_ff.gpio_pin.out;
  assign gpio_oe            = cur_ff.gpio_pin.oe;
  assign secondary_reset_n  = cur_ff.sec_reset_n;
  assign target_enables     = cur_ff.eff;
  assign return_completions = cur_ff.ret_cpl;
  assign insertion_event_n  = ~(hotswap & cur_ff.insert_evt);
  assign removal_ready_lamp = hotswap & cur_ff.ctrl[`CTRL_LAMP];

  assign axil_rsp.awready = ~cur_ff.aw_held & ~cur_ff.bvalid;
  assign axil_rsp.wready  = ~cur_ff.w_held & ~cur_ff.bvalid;
  assign axil_rsp.bvalid  = cur_ff.bvalid;
  assign axil_rsp.bresp   = cur_ff.bresp;
  assign axil_rsp.arready = ~cur_ff.rvalid;
  assign axil_rsp.rvalid  = cur_ff.rvalid;
  assign axil_rsp.rdata   = cur_ff.rdata;
  assign axil_rsp.rresp   = cur_ff.rresp;

endmodule
`default_nettype wire

// file: clock_mask_sva.sv
`timescale 1ns/1ps
`default_nettype none
module clock_mask_sva #(
  parameter logic [15:0] HOLD_CYCLES = 16'h0014
) (
  input wire logic                      aclk,               // Primary clock
  input wire logic                      aresetn,            // Primary reset
  input wire clock_mask_pkg::axil_req_s axil_req,           // Bus request
  input wire clock_mask_pkg::axil_rsp_s axil_rsp,           // Bus response
  input wire logic [3:0]                gpio_out,           // Pin values
  input wire logic [3:0]                gpio_oe,            // Pin enables
  input wire logic                      mode_select_0,      // Mode strap 0
  input wire logic                      mode_select_1,      // Mode strap 1
  input wire logic                      secondary_reset_n,  // Secondary reset
  input wire clock_mask_pkg::enables_s  target_enables,     // Enables
  input wire logic                      return_completions, // Completions ok
  input wire logic                      insertion_event_n,  // Event
  input wire logic                      removal_ready_lamp  // Lamp
);
  logic        shift;
  logic        load;
  logic [7:0]  shift_cnt_ff;
  logic [15:0] low_cnt_ff;

  assign shift = gpio_oe[2] & gpio_out[2];
  assign load  = gpio_oe[0] & gpio_out[0];

  // Run lengths kept in counters; repetition would need 16 copies
  always_ff @(posedge aclk) begin
    shift_cnt_ff <= shift ? shift_cnt_ff + 8'h01 : 8'h00;
    low_cnt_ff   <= (!aresetn || secondary_reset_n) ? 16'h0000
                    : low_cnt_ff + 16'h0001;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  load_pulse_a: assert property (load |-> gpio_oe[2] ##1 !load)
    else $error("load pulse malformed");
  load_first_a: assert property ($rose(shift) |-> $past(load))
    else $error("shift without load");
  shift_len_a: assert property ($fell(shift) |-> shift_cnt_ff == 8'h10)
    else $error("shift length not sixteen");
  pins_release_a: assert property ($fell(shift) |-> gpio_oe == 4'h0)
    else $error("pins still driven after shift");
  reset_shift_a: assert property (shift |-> !secondary_reset_n)
    else $error("secondary reset released during shift");
  hold_time_a: assert property (
    $rose(secondary_reset_n) |-> low_cnt_ff >= HOLD_CYCLES)
    else $error("secondary reset hold too short");
  mode_lamp_a: assert property ((mode_select_0 || mode_select_1)
    |-> insertion_event_n && !removal_ready_lamp)
    else $error("hot-swap outputs active outside hot-swap");
  hotswap_live_a: assert property (
    (!mode_select_0 && !mode_select_1) |-> return_completions)
    else $error("live masking in hot-swap mode");
  masked_cpl_a: assert property (
    !return_completions |-> target_enables == 3'b000)
    else $error("completions held with enables live");
  write_busy_a: assert property (
    axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
    else $error("write accepted with response pending");
  read_busy_a: assert property (axil_rsp.rvalid |-> !axil_rsp.arready)
    else $error("read accepted with data pending");

  cover property ($fell(shift));
  cover property ($rose(secondary_reset_n));
  cover property (!return_completions);
endmodule

bind clock_mask_ctrl clock_mask_sva #(.HOLD_CYCLES(HOLD_CYCLES)) i_sva (
  .aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .mode_select_0(mode_select_0),
  .mode_select_1(mode_select_1), .secondary_reset_n(secondary_reset_n),
  .target_enables(target_enables), .return_completions(return_completions),
  .insertion_event_n(insertion_event_n),
  .removal_ready_lamp(removal_ready_lamp)
);
`default_nettype wire

// file: mask_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module mask_shifter (
  input  wire logic [0:0]  aclk,           // Primary clock
  input  wire logic [3:0]  gpio_out,       // Pin values
  input  wire logic [3:0]  gpio_oe,        // Pin enables
  input  wire logic [15:0] load_value,     // Parallel mask contents
  output logic             mask_serial_in  // Serial mask bit
);
  logic [15:0] sr_ff;
  logic        last_ff = 1'b0;
  logic        shift;
  assign shift = gpio_oe[2] & gpio_out[2];
  always @(posedge aclk) begin
    if (gpio_oe[0] & gpio_out[0])
      sr_ff <= load_value;
    else if (shift)
      sr_ff <= {1'b0, sr_ff[15:1]};
    last_ff <= mask_serial_in;
  end
  // Outside a shift the line flips so stale bits cannot pass as data
  assign mask_serial_in = shift ? sr_ff[0] : ~last_ff;
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_mask_regs.svh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin bad_count++; $display("FAIL %0t %s", $time, m); end end
module testbench;
  localparam int HOLD = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic pss = 1'b0, sss = 1'b0, ms0 = 1'b1, ms1 = 1'b0;
  logic [3:0] gin, gout, goe;
  logic [3:0] ext = 4'h0;
  logic [9:0] sck;
  logic srst_n, cpl, evt_n, lamp, msin;
  logic [15:0] mval = 16'h0000;
  logic [31:0] q;
  logic [1:0] r;
  int bad_count = 0;
  int compares = 0;
  clock_mask_pkg::axil_req_s req = '0;
  clock_mask_pkg::axil_rsp_s rsp;
  clock_mask_pkg::enables_s en;
  logic [15:0] masks [4] = '{16'h0000, 16'hffff, 16'he521, 16'h1a9e};
  logic [3:0] straps [4] = '{4'b0010, 4'b1010, 4'b1110, 4'b0110};

  always #10 aclk = ~aclk;
  assign gin = (goe & gout) | (~goe & ext);

  clock_mask_ctrl #(.HOLD_CYCLES(16'(HOLD))) i_dut (.aclk(aclk),
    .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .mask_serial_in(msin),
    .gpio_in(gin), .gpio_out(gout), .gpio_oe(goe),
    .primary_speed_select(pss), .secondary_speed_select(sss),
    .mode_select_0(ms0), .mode_select_1(ms1), .secondary_clock_output(sck),
    .secondary_reset_n(srst_n), .target_enables(en),
    .return_completions(cpl), .insertion_event_n(evt_n),
    .removal_ready_lamp(lamp));
  mask_shifter i_shifter (.aclk(aclk), .gpio_out(gout), .gpio_oe(goe),
    .load_value(mval), .mask_serial_in(msin));

  task automatic tally_and_finish;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rq,
                     output logic [1:0] rr);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    rq = 32'h0;
    rr = 2'h0;
    // One edge apart, so back-to-back calls never drive a signal twice
    @(posedge aclk);
    if (wr) begin
      req.awaddr <= {24'h0, a};
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
    end else begin
      req.araddr <= {24'h0, a};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
    end
    while (!done) begin
      @(posedge aclk);
      n++;
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (wr && req.bready && rsp.bvalid) begin
        rr = rsp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
      if (!wr && req.rready && rsp.rvalid) begin
        rr = rsp.rresp;
        rq = rsp.rdata;
        req.rready <= 1'b0;
        done = 1'b1;
      end
      if (n > 300) begin
        bad_count++;
        $display("FAIL %0t bus timeout", $time);
        tally_and_finish;
      end
    end
  endtask

  task automatic wait_rel(output int n);
    n = 0;
    while (srst_n !== 1'b1 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 500) begin
      bad_count++;
      $display("FAIL %0t secondary reset stuck", $time);
      tally_and_finish;
    end
  endtask

  task automatic boot(input logic [15:0] m, input logic [3:0] s);
    int n;
    aresetn <= 1'b0;
    mval <= m;
    {pss, sss, ms0, ms1} <= s;
    repeat (16) @(posedge aclk);
    `CHK(sck, 10'h000, "clock active in reset")
    aresetn <= 1'b1;
    wait_rel(n);
    `CHK(n >= HOLD + 16, 1'b1, "secondary reset released early")
    $display("boot done mask %h", m);
  endtask

  task automatic clocks(input logic [15:0] m, input logic div);
    logic [9:0] prev;
    int ch [10];
    logic dis;
    ch = '{default: 0};
    #5 prev = sck;
    repeat (8) begin
      #10;
      for (int i = 0; i < 10; i++)
        if (sck[i] !== prev[i])
          ch[i]++;
      prev = sck;
    end
    for (int i = 0; i < 10; i++) begin
      dis = (i < 4) ? |m[2*i +: 2] : m[i + 4];
      `CHK(ch[i], dis ? 0 : (div ? 4 : 8), "clock activity")
      `CHK(sck[i] | ~dis, 1'b1, "disabled clock not high")
    end
    @(posedge aclk);
    $display("clock test done");
  endtask

  initial begin
    int n;
    for (int k = 0; k < 4; k++) begin
      boot(masks[k], straps[k]);
      clocks(masks[k], straps[k][3] & ~straps[k][2]);
      bus(1'b0, `OFS_CLOCK_MASK, 32'h0, q, r);
      `CHK(q[15:0], masks[k], "mask readback")
    end
    bus(1'b0, `OFS_GPIO, 32'h0, q, r);
    `CHK(q[11:8], 4'h0, "pins not input after boot")
    bus(1'b1, `OFS_CLOCK_MASK, 32'h0000_0003, q, r);
    clocks(16'h0003, 1'b0);
    bus(1'b1, `OFS_BRIDGE_CTRL, 32'h0000_001e, q, r);
    ext[3] <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(en, 3'b000, "enables not masked")
    `CHK(cpl, 1'b0, "completions not held")
    bus(1'b0, `OFS_BRIDGE_CTRL, 32'h0, q, r);
    `CHK({r, q[5:0]}, {`RESP_OKAY, 6'h1e}, "control readback")
    bus(1'b1, `OFS_GPIO, 32'h0000_0808, q, r);
    repeat (4) @(posedge aclk);
    `CHK(en, 3'b111, "driven pin still masks")
    bus(1'b0, `OFS_GPIO, 32'h0, q, r);
    `CHK({q[11:8], q[3:0]}, 8'h88, "pin set fields")
    bus(1'b1, `OFS_GPIO, 32'h0000_8000, q, r);
    ext[3] <= 1'b0;
    repeat (4) @(posedge aclk);
    `CHK(en, 3'b111, "enables not restored")
    bus(1'b0, `OFS_GPIO, 32'h0, q, r);
    `CHK({q[11:8], q[3:0]}, 8'h08, "pin clear fields")
    $display("live insertion test done");
    bus(1'b1, `OFS_BRIDGE_CTRL, 32'h0000_001f, q, r);
    repeat (4) @(posedge aclk);
    `CHK(srst_n, 1'b0, "reset bit ignored")
    bus(1'b1, `OFS_BRIDGE_CTRL, 32'h0000_001e, q, r);
    wait_rel(n);
    `CHK(n >= HOLD - 4, 1'b1, "hold skipped after clear")
    bus(1'b0, 8'h10, 32'h0, q, r);
    `CHK({r, q}, {`RESP_SLVERR, 32'h0}, "unmapped read")
    boot(16'h0000, 4'b0000);
    bus(1'b1, `OFS_BRIDGE_CTRL, 32'h0000_003e, q, r);
    ext[3] <= 1'b1;
    repeat (4) @(posedge aclk);
    `CHK(en, 3'b111, "live masking in hot-swap")
    `CHK({lamp, evt_n}, 2'b10, "lamp or event wrong")
    bus(1'b0, `OFS_STATUS, 32'h0, q, r);
    `CHK(q[4], 1'b1, "hot-swap mode not seen")
    bus(1'b1, `OFS_STATUS, 32'h0000_0100, q, r);
    repeat (2) @(posedge aclk);
    `CHK(evt_n, 1'b1, "event not cleared")
    $display("hot-swap test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
